// ---- src/bsio_pkg.sv ----
// package for the bit serial io port: opcodes, field layouts, timing counts
// assumes a single 50 MHz clock; phase-three ticks come from an internal divider
package bsio_pkg;
  localparam int CLK_MHZ = 50;
  localparam int PHASE_NS = 500;
  localparam int PHASE_CYC = (PHASE_NS * CLK_MHZ + 999) / 1000;
  localparam int PHASE_W = 5;
  localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(PHASE_CYC - 1);
  localparam int ADDR_W = 11;
  localparam int BASE_LSB = 1;
  localparam int BIT_EQ = 2;
  localparam int DISP_W = 8;
  localparam int CNT_W = 4;
  localparam int MAX_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int BYTE_MSB_BIT = 8;
  localparam int WORD_W = 16;

  typedef enum logic [2:0] {
    BSIO_OP_SET_ONE,
    BSIO_OP_SET_ZERO,
    BSIO_OP_TEST,
    BSIO_OP_LOAD,
    BSIO_OP_STORE
  } bsio_op_t;

  typedef struct packed {
    bsio_op_t op;
    logic [WORD_W-1:0] base;
    logic [DISP_W-1:0] disp;
    logic [CNT_W-1:0] count;
    logic [WORD_W-1:0] data;
  } bsio_req_t;

  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic eq_flag;
    logic eq_valid;
  } bsio_rsp_t;
endpackage

// ---- src/bsio_buf2.sv ----
// two-entry valid/ready buffer for finished-operation results
// assumes single clock, synchronous active-low reset
`timescale 1ns/1ps
module bsio_buf2 (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire bsio_pkg::bsio_rsp_t in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output bsio_pkg::bsio_rsp_t out_data_out
);
  import bsio_pkg::*;
  bsio_rsp_t mem [2];
  bsio_rsp_t next_mem [2];
  logic wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [1:0] fill, next_fill;
  logic push, pop;

  assign in_ready_out = (fill != 2'h2);
  assign out_valid_out = (fill != 2'h0);
  assign out_data_out = mem[rd_ptr];

  always_comb begin
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_mem[wr_ptr] = in_data_in;
      next_wr_ptr = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    next_fill = fill + 2'(push) - 2'(pop);
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      mem[0] <= '0;
      mem[1] <= '0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill <= 2'h0;
    end else begin
      mem <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill <= next_fill;
    end
  end

  a_buf_no_overflow: assert property (@(posedge clk_in) disable iff (!resetn_in)
    fill <= 2'h2) else $error("buffer fill above two");
endmodule

// ---- src/bsio_port.sv ----
// processor side of the bit serial io port: address, strobe, serial in/out sequencing
// assumes peripherals decode the bit address when the memory-cycle enable is high
`timescale 1ns/1ps

module bsio_port (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire bsio_pkg::bsio_req_t req_in,
  output logic rsp_valid_out,
  input wire logic rsp_ready_in,
  output bsio_pkg::bsio_rsp_t rsp_out,
  output logic [bsio_pkg::ADDR_W-1:0] bit_address_out,
  output logic memory_cycle_enable_n_out,
  output logic serial_bit_output_out,
  output logic bit_output_strobe_out,
  input wire logic serial_bit_input_in
);
  import bsio_pkg::*;

  typedef enum logic [1:0] {
    BSIO_IDLE,
    BSIO_ADDR,
    BSIO_XFER,
    BSIO_DONE
  } bsio_state_t;

  // sign-extended displacement added to the hardware base address
  function automatic logic [ADDR_W-1:0] bsio_bit_addr(input logic [WORD_W-1:0] base, input logic [DISP_W-1:0] disp);
    bsio_bit_addr = base[BASE_LSB +: ADDR_W] + {{(ADDR_W-DISP_W){disp[DISP_W-1]}}, disp};
  endfunction

  function automatic logic [4:0] bsio_len(input logic [CNT_W-1:0] c);
    bsio_len = (c == '0) ? 5'(MAX_BITS) : {1'b0, c};
  endfunction

  bsio_state_t state, next_state;
  bsio_op_t op, next_op;
  logic [PHASE_W-1:0] div, next_div;
  logic phase3;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [4:0] left, next_left;
  logic [4:0] total, next_total;
  logic [WORD_W-1:0] sreg, next_sreg;
  logic [WORD_W-1:0] acc, next_acc;
  logic mce, next_mce;
  logic sout, next_sout;
  logic strobe, next_strobe;
  logic byte_mode, next_byte_mode;
  logic res_valid, res_ready;
  bsio_rsp_t res, next_res;
  logic out_op;

  // phase-three enable, one pulse per divided phase
  always_comb begin
    next_div = (div == PHASE_LAST) ? '0 : div + PHASE_W'(1);
  end
  assign phase3 = (div == PHASE_LAST);

  assign out_op = (op == BSIO_OP_SET_ONE) || (op == BSIO_OP_SET_ZERO) || (op == BSIO_OP_LOAD);
  assign req_ready_out = (state == BSIO_IDLE);
  assign res_valid = (state == BSIO_DONE);

  always_comb begin
    next_state = state;
    next_op = op;
    next_addr = addr;
    next_left = left;
    next_total = total;
    next_sreg = sreg;
    next_acc = acc;
    next_mce = mce;
    next_sout = sout;
    next_strobe = 1'b0;
    next_byte_mode = byte_mode;
    next_res = res;
    case (state)
      BSIO_IDLE: begin
        if (req_valid_in) begin
          next_op = req_in.op;
          next_acc = req_in.data;
          next_byte_mode = 1'b0;
          if (req_in.op == BSIO_OP_LOAD || req_in.op == BSIO_OP_STORE) begin
            next_addr = bsio_bit_addr(req_in.base, '0);
            next_total = bsio_len(req_in.count);
            next_byte_mode = (bsio_len(req_in.count) <= 5'(BYTE_BITS));
            // byte mode shifts from bit 8, the upper byte's lsb
            next_sreg = (bsio_len(req_in.count) <= 5'(BYTE_BITS)) ?
                        (req_in.data >> BYTE_MSB_BIT) : req_in.data;
          end else begin
            next_addr = bsio_bit_addr(req_in.base, req_in.disp);
            next_total = 5'h01;
            next_sreg = {{(WORD_W-1){1'b0}}, req_in.op == BSIO_OP_SET_ONE};
          end
          next_left = next_total;
          next_state = BSIO_ADDR;
        end
      end
      BSIO_ADDR: begin
        // address steps at a phase three so it still stands through the strobe
        if (phase3) begin
          if (left != total) begin
            next_addr = addr + ADDR_W'(1);
          end
          next_mce = 1'b1;
          next_state = BSIO_XFER;
        end
      end
      BSIO_XFER: begin
        if (phase3) begin
          if (out_op) begin
            next_sout = sreg[0];
            next_strobe = 1'b1;
            next_sreg = sreg >> 1;
          end else begin
            // peripheral holds the bit two phases from phase three, so sample now
            next_sreg = {serial_bit_input_in, sreg[WORD_W-1:1]};
          end
          next_left = left - 5'h01;
          // enable held over the last strobe, dropped one cycle later
          if (left == 5'h01) begin
            next_state = BSIO_DONE;
          end else begin
            next_state = BSIO_ADDR;
          end
        end
      end
      BSIO_DONE: begin
        next_mce = 1'b0;
        next_res.eq_valid = (op == BSIO_OP_TEST);
        next_res.eq_flag = (op == BSIO_OP_TEST) ? sreg[WORD_W-1] : 1'b0;
        next_res.data = acc;
        if (op == BSIO_OP_STORE) begin
          // right-justify collected bits, zero-fill above them; in byte mode within the upper byte, low byte from acc[7:0]
          if (byte_mode) begin
            next_res.data = {8'h00 | 8'(sreg >> (WORD_W - 32'(total))), acc[7:0]};
          end else begin
            next_res.data = sreg >> (WORD_W - 32'(total));
          end
        end
        if (res_ready) begin
          next_state = BSIO_IDLE;
        end
      end
      default: next_state = BSIO_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state <= BSIO_IDLE;
      op <= BSIO_OP_SET_ZERO;
      div <= '0;
      addr <= '0;
      left <= '0;
      total <= '0;
      sreg <= '0;
      acc <= '0;
      mce <= 1'b0;
      sout <= 1'b0;
      strobe <= 1'b0;
      byte_mode <= 1'b0;
      res <= '0;
    end else begin
      state <= next_state;
      op <= next_op;
      div <= next_div;
      addr <= next_addr;
      left <= next_left;
      total <= next_total;
      sreg <= next_sreg;
      acc <= next_acc;
      mce <= next_mce;
      sout <= next_sout;
      strobe <= next_strobe;
      byte_mode <= next_byte_mode;
      res <= next_res;
    end
  end

  // result computed combinationally in DONE, pushed through the buffer
  bsio_rsp_t res_word;
  always_comb begin
    res_word = next_res;
  end

  bsio_buf2 u_buf (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(res_valid),
    .in_ready_out(res_ready),
    .in_data_in(res_word),
    .out_valid_out(rsp_valid_out),
    .out_ready_in(rsp_ready_in),
    .out_data_out(rsp_out)
  );

  assign bit_address_out = addr;
  // low selects memory, high marks a bit address on the lines
  assign memory_cycle_enable_n_out = mce;
  assign serial_bit_output_out = sout;
  assign bit_output_strobe_out = strobe;

  a_strobe_only_out: assert property (@(posedge clk_in) disable iff (!resetn_in)
    strobe |-> out_op) else $error("strobe during input operation");
  a_strobe_in_cycle: assert property (@(posedge clk_in) disable iff (!resetn_in)
    strobe |-> mce) else $error("strobe outside io cycle");
  a_strobe_addr: assert property (@(posedge clk_in) disable iff (!resetn_in)
    strobe |-> $stable(addr)) else $error("address moved under strobe");
  a_strobe_pulse: assert property (@(posedge clk_in) disable iff (!resetn_in)
    strobe |=> !strobe) else $error("strobe longer than one cycle");
  a_addr_step: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == BSIO_ADDR && phase3 && left != total) |=> addr == $past(addr) + ADDR_W'(1))
    else $error("address did not increment");
  a_strobe_spacing: assert property (@(posedge clk_in) disable iff (!resetn_in)
    strobe |=> !strobe [*8]) else $error("strobes too close");
  a_set_data: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (strobe && op == BSIO_OP_SET_ONE) |-> sout) else $error("set-one sent zero");
  a_clr_data: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (strobe && op == BSIO_OP_SET_ZERO) |-> !sout) else $error("set-zero sent one");
  a_done_mce_low: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == BSIO_DONE) |=> !mce) else $error("enable high after transfer");
  a_idle_mce_low: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == BSIO_IDLE) |-> !mce) else $error("enable high while idle");
  a_single_addr: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state == BSIO_IDLE && req_valid_in && req_in.op == BSIO_OP_TEST) |=>
    addr == bsio_bit_addr($past(req_in.base), $past(req_in.disp))) else $error("bad bit address");

  c_load: cover property (@(posedge clk_in) op == BSIO_OP_LOAD && state == BSIO_DONE);
  c_store: cover property (@(posedge clk_in) op == BSIO_OP_STORE && state == BSIO_DONE);
  c_test: cover property (@(posedge clk_in) op == BSIO_OP_TEST && state == BSIO_DONE);
endmodule

// ---- dv/bsio_periph.sv ----
// far-side model: one io bit per bit address, latched on strobe, read back on serial input
// assumes the port's registered address, strobe and enable; io cycle = enable high
`timescale 1ns/1ps
module bsio_periph (
  input wire logic clk_in,
  input wire logic [bsio_pkg::ADDR_W-1:0] bit_address_in,
  input wire logic memory_cycle_enable_n_in,
  input wire logic serial_bit_output_in,
  input wire logic bit_output_strobe_in,
  output logic serial_bit_input_out
);
  import bsio_pkg::*;
  logic io_bits [0:(1<<ADDR_W)-1];
  logic last_bit = 1'b0;
  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) io_bits[i] = ^(i * 37);
  end
  // latch only inside an io cycle, like a decoded latch
  always @(posedge clk_in) begin
    if (bit_output_strobe_in === 1'b1 && memory_cycle_enable_n_in === 1'b1) io_bits[bit_address_in] <= serial_bit_output_in;
    if (memory_cycle_enable_n_in === 1'b1) last_bit <= io_bits[bit_address_in];
  end
  // bit stands as long as its address, past two phases
  // deselected: inverse of last value so a late sample never looks right
  assign serial_bit_input_out = (memory_cycle_enable_n_in === 1'b1) ? io_bits[bit_address_in] : ~last_bit;
endmodule

// ---- dv/bsio_port_tb.sv ----
// testbench for the bit serial io port: reset, operation table, then stall and abort cases
// assumes bsio_periph as far side; inputs change on falling edges
`timescale 1ns/1ps
module bsio_port_tb;
  import bsio_pkg::*;
  typedef struct {bsio_op_t op; logic [15:0] base; logic [7:0] disp; logic [3:0] cnt; logic [15:0] data; int nstb;} bsio_row_t;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic req_valid_in = 1'b0;
  logic rsp_ready_in = 1'b1;
  bsio_req_t req_in = '0;
  logic req_ready_out, rsp_valid_out, mce_n, single_bit_set_one, stb, sbi;
  bsio_rsp_t rsp_out, got;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W:0] sq[$];
  int errors = 0;
  int comparisons = 0;
  bsio_row_t rows[16];
  always #10 clk_in = ~clk_in;
  bsio_port dut (.clk_in(clk_in), .resetn_in(resetn_in), .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
    .req_in(req_in), .rsp_valid_out(rsp_valid_out), .rsp_ready_in(rsp_ready_in), .rsp_out(rsp_out),
    .bit_address_out(addr), .memory_cycle_enable_n_out(mce_n), .serial_bit_output_out(single_bit_set_one),
    .bit_output_strobe_out(stb), .serial_bit_input_in(sbi));
  bsio_periph periph (.clk_in(clk_in), .bit_address_in(addr), .memory_cycle_enable_n_in(mce_n),
    .serial_bit_output_in(single_bit_set_one), .bit_output_strobe_in(stb), .serial_bit_input_out(sbi));
  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(negedge clk_in) begin
    if (resetn_in && stb === 1'b1) begin
      sq.push_back({addr, single_bit_set_one});
      chk(mce_n === 1'b1, "strobe outside io cycle");
    end
  end
  task automatic send(input bsio_op_t op, input logic [15:0] base, input logic [7:0] disp, input logic [3:0] cnt,
    input logic [15:0] data);
    int t = 0;
    while (req_ready_out !== 1'b1 && t < 3000) begin
      @(negedge clk_in);
      t++;
    end
    chk(t < 3000, "request not taken");
    req_in = '{op: op, base: base, disp: disp, count: cnt, data: data};
    req_valid_in = 1'b1;
    @(negedge clk_in);
    req_valid_in = 1'b0;
  endtask
  task automatic take;
    int t = 0;
    while (rsp_valid_out !== 1'b1 && t < 3000) begin
      @(negedge clk_in);
      t++;
    end
    chk(t < 3000, "no response");
    got = rsp_out;
    @(negedge clk_in);
  endtask
  task automatic run_op(input bsio_row_t r);
    logic [ADDR_W-1:0] b, a;
    logic [15:0] exp;
    logic eq;
    int n, k;
    b = r.base[11:1];
    a = b + {{3{r.disp[7]}}, r.disp};
    n = (r.cnt == 0) ? 16 : r.cnt;
    k = (n > 8) ? 0 : 8;
    exp = (n > 8) ? 16'h0000 : {8'h00, r.data[7:0]};
    for (int i = 0; i < n; i++) exp[k + i] = periph.io_bits[ADDR_W'(b + i)];
    eq = periph.io_bits[a];
    sq.delete();
    send(r.op, r.base, r.disp, r.cnt, r.data);
    take();
    chk(sq.size() == r.nstb, "strobe count");
    if (r.op == BSIO_OP_LOAD) begin
      for (int i = 0; i < sq.size(); i++) chk(sq[i] === {ADDR_W'(b + i), r.data[k + i]}, "load bit");
    end
    if (r.op == BSIO_OP_SET_ONE || r.op == BSIO_OP_SET_ZERO) chk(sq[0] === {a, r.op == BSIO_OP_SET_ONE}, "set bit");
    if (r.op == BSIO_OP_TEST) chk(got.eq_valid === 1'b1 && got.eq_flag === eq, "test flag");
    if (r.op == BSIO_OP_STORE) chk(got.data === exp, "store data");
    chk(mce_n === 1'b0, "enable left in io state");
  endtask
  task automatic do_reset;
    resetn_in = 1'b0;
    repeat (5) @(negedge clk_in);
    chk(stb === 1'b0 && mce_n === 1'b0 && req_ready_out === 1'b1 && rsp_valid_out === 1'b0, "reset values");
    resetn_in = 1'b1;
  endtask
  initial begin
    #1000000;
    errors++;
    $display("[FAIL] %0t watchdog", $time);
    results();
  end
  initial begin
    rows = '{'{BSIO_OP_SET_ONE, 16'h0020, 8'h00, 4'h0, 16'h0000, 1}, '{BSIO_OP_TEST, 16'h0020, 8'h00, 4'h0, 16'h0000, 0},
      '{BSIO_OP_SET_ZERO, 16'h0020, 8'h01, 4'h0, 16'h0000, 1}, '{BSIO_OP_TEST, 16'h0000, 8'h11, 4'h0, 16'h0000, 0},
      '{BSIO_OP_SET_ONE, 16'h0800, 8'hFF, 4'h0, 16'h0000, 1}, '{BSIO_OP_SET_ZERO, 16'h0000, 8'h7F, 4'h0, 16'h0000, 1},
      '{BSIO_OP_TEST, 16'h0100, 8'h80, 4'h0, 16'h0000, 0}, '{BSIO_OP_LOAD, 16'h0020, 8'h00, 4'h9, 16'hA5C3, 9},
      '{BSIO_OP_LOAD, 16'h0020, 8'h00, 4'h4, 16'h5A00, 4}, '{BSIO_OP_LOAD, 16'h0040, 8'h00, 4'h0, 16'h1234, 16},
      '{BSIO_OP_STORE, 16'h0020, 8'h00, 4'h9, 16'hFFFF, 0}, '{BSIO_OP_STORE, 16'h0020, 8'h00, 4'h4, 16'h00A5, 0},
      '{BSIO_OP_STORE, 16'h0040, 8'h00, 4'h0, 16'h0000, 0}, '{BSIO_OP_STORE, 16'h0020, 8'h00, 4'h8, 16'hFFFF, 0},
      '{BSIO_OP_LOAD, 16'h0020, 8'h00, 4'h8, 16'h8000, 8}, '{BSIO_OP_LOAD, 16'h0020, 8'h00, 4'h1, 16'h0100, 1}};
    do_reset();
    foreach (rows[i]) begin
      run_op(rows[i]);
      $display("row %0d done", i);
    end
    // receiver stalls: two results buffered, third holds the port busy
    rsp_ready_in = 1'b0;
    for (int i = 1; i <= 3; i++) send(BSIO_OP_STORE, 16'h0020, 8'h00, 4'h1, 16'(i * 16'h0011));
    repeat (200) @(negedge clk_in);
    chk(req_ready_out === 1'b0 && rsp_valid_out === 1'b1, "stall not held");
    rsp_ready_in = 1'b1;
    for (int i = 1; i <= 3; i++) begin
      take();
      chk(got.data[7:0] === 8'(i * 8'h11), "buffer order");
    end
    $display("stall done");
    // abort a long load by reset, then check the port recovers
    send(BSIO_OP_LOAD, 16'h0040, 8'h00, 4'h0, 16'hFFFF);
    repeat (100) @(negedge clk_in);
    do_reset();
    run_op(rows[2]);
    $display("abort done");
    results();
  end
endmodule
